/* rtl/mwe_top.sv */
// Memory word error correction for four storage stacks
`timescale 1ns/1ps
module mwe_top
    import mwe_pkg::*;
#(
    parameter int STACKS = NUM_STACKS
)(
    // Clock and reset
    input  wire logic                          MCLK_I,
    input  wire logic                          SYS_RST_I,
    // Write side, from memory control
    input  wire mwe_wr_req_t [STACKS-1:0]      WR_REQ_I,
    output logic        [STACKS-1:0][WORD_W-1:0] WR_WORD_O,
    output logic        [STACKS-1:0]           WR_VLD_O,
    // Read side, from storage stacks
    input  wire logic   [STACKS-1:0]           RD_VLD_I,
    input  wire logic   [STACKS-1:0][WORD_W-1:0] RD_WORD_I,
    output mwe_rd_rsp_t [STACKS-1:0]           RD_RSP_O
);

    // ==========================================
    // Elaboration check
    if (STACKS != NUM_STACKS) begin : g_bad_stacks
        $error("STACKS must equal four");
    end

    // ==========================================
    // State
    typedef struct packed {
        mwe_lane_t [STACKS-1:0] lane;
    } mwe_state_t;

    mwe_state_t state_r;
    mwe_state_t state_nxt;

    logic [STACKS-1:0][CHK_W-1:0]  wr_chk;
    logic [STACKS-1:0][CHK_W-1:0]  rd_syn;
    logic [STACKS-1:0][WORD_W-1:0] rd_flip;
    logic [STACKS-1:0]             rd_sbe;
    logic [STACKS-1:0]             rd_mbe;

    // ==========================================
    // Per-stack encoder and decoder
    genvar si;
    generate
        for (si = 0; si < STACKS; si++) begin : g_stack
            mwe_syndrome u_enc (
                .data_i    (WR_REQ_I[si].data),
                .chk_i     ('0),
                .gen_chk_o (wr_chk[si]),
                .syn_o     (),
                .flip_o    (),
                .sbe_o     (),
                .mbe_o     ()
            );
            mwe_syndrome u_dec (
                .data_i    (RD_WORD_I[si][DATA_W-1:0]),
                .chk_i     (RD_WORD_I[si][WORD_W-1:CHK_LSB]),
                .gen_chk_o (),
                .syn_o     (rd_syn[si]),
                .flip_o    (rd_flip[si]),
                .sbe_o     (rd_sbe[si]),
                .mbe_o     (rd_mbe[si])
            );
        end
    endgenerate

    // ==========================================
    // Next state
    always_comb begin
        logic [WORD_W-1:0] fixed;
        fixed     = '0;
        state_nxt = state_r;
        for (int i = 0; i < STACKS; i++) begin
            state_nxt.lane[i].wr_vld  = WR_REQ_I[i].vld;
            if (WR_REQ_I[i].vld) begin
                state_nxt.lane[i].wr_word = {
                    WR_REQ_I[i].inv_chk ? ~wr_chk[i] : wr_chk[i],
                    WR_REQ_I[i].data};
            end
            state_nxt.lane[i].rd.vld = RD_VLD_I[i];
            if (RD_VLD_I[i]) begin
                fixed = RD_WORD_I[i];
                if (!rd_mbe[i]) begin
                    fixed = RD_WORD_I[i] ^ rd_flip[i];
                end
                state_nxt.lane[i].rd.data     = fixed[DATA_W-1:0];
                state_nxt.lane[i].rd.sbe      = rd_sbe[i];
                state_nxt.lane[i].rd.mbe      = rd_mbe[i];
                state_nxt.lane[i].rd.syndrome = rd_syn[i];
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================
    // Outputs
    always_comb begin
        for (int i = 0; i < STACKS; i++) begin
            WR_WORD_O[i] = state_r.lane[i].wr_word;
            WR_VLD_O[i]  = state_r.lane[i].wr_vld;
            RD_RSP_O[i]  = state_r.lane[i].rd;
        end
    end

endmodule

/* rtl/mwe_pkg.sv */
// Package for the memory word error-correction block
package mwe_pkg;

    // ==========================================
    // Word layout
    localparam int DATA_W     = 16;
    localparam int CHK_W      = 6;
    localparam int WORD_W     = 22;
    localparam int CHK_LSB    = 16;
    localparam int NUM_STACKS = 4;

    // Data bits covered by each check bit (bit n of mask -> data bit n)
    localparam logic [CHK_W-1:0][DATA_W-1:0] CHK_MASK = '{
        16'hD4D4,   // Check 21: 2,4,6,7,10,12,14,15
        16'hBAA2,   // Check 20: 1,5,7,9,11,12,13,15
        16'h6969,   // Check 19: 0,3,5,6,8,11,13,14
        16'hE718,   // Check 18: 3,4,8,9,10,13,14,15
        16'h1F07,   // Check 17: 0,1,2,8,9,10,11,12
        16'h00FF    // Check 16: 0..7
    };

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 22'h00_0000;

    // Write request carrier
    typedef struct packed {
        logic                 vld;
        logic                 inv_chk;
        logic [DATA_W-1:0]    data;
    } mwe_wr_req_t;

    // Read result carrier
    typedef struct packed {
        logic                 vld;
        logic                 sbe;
        logic                 mbe;
        logic [CHK_W-1:0]     syndrome;
        logic [DATA_W-1:0]    data;
    } mwe_rd_rsp_t;

    // Per-stack pipeline state
    typedef struct packed {
        logic [WORD_W-1:0]    wr_word;
        logic                 wr_vld;
        mwe_rd_rsp_t          rd;
    } mwe_lane_t;

endpackage

/* rtl/mwe_syndrome.sv */
// Check-bit generator and syndrome decoder for one 22-bit word
`timescale 1ns/1ps
module mwe_syndrome
    import mwe_pkg::*;
(
    // Word to check
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic [CHK_W-1:0]  chk_i,
    // Results
    output logic      [CHK_W-1:0]  gen_chk_o,
    output logic      [CHK_W-1:0]  syn_o,
    output logic      [WORD_W-1:0] flip_o,
    output logic                   sbe_o,
    output logic                   mbe_o
);

    // ==========================================
    // Check bits and syndrome
    genvar gi;
    generate
        for (gi = 0; gi < CHK_W; gi++) begin : g_chk
            assign gen_chk_o[gi] = ~(^(data_i & CHK_MASK[gi]));
            assign syn_o[gi]     = ~(^(data_i & CHK_MASK[gi]) ^ chk_i[gi]);
        end
    endgenerate

    // ==========================================
    // Single-bit pattern match per word position
    logic [WORD_W-1:0] pat_hit;
    genvar pj;
    generate
        for (pj = 0; pj < WORD_W; pj++) begin : g_pat
            logic [CHK_W-1:0] pat;
            if (pj < DATA_W) begin : g_d
                for (genvar k = 0; k < CHK_W; k++) begin : g_k
                    assign pat[k] = CHK_MASK[k][pj];
                end
            end else begin : g_c
                assign pat = CHK_W'(1) << (pj - DATA_W);
            end
            assign pat_hit[pj] = (syn_o == pat);
        end
    endgenerate

    // ==========================================
    // Classification
    assign flip_o = pat_hit;
    assign sbe_o  = |pat_hit;
    assign mbe_o  = (syn_o != '0) && !(|pat_hit);

endmodule

/* verif/mwe_checker.sv */
// Assertions on the memory word error-correction block, watched on stack 1
`timescale 1ns/1ps
module mwe_checker
    import mwe_pkg::*;
#(
    parameter int STACKS = NUM_STACKS
)(
    // Watched ports
    input wire logic                          MCLK_I,
    input wire logic                          SYS_RST_I,
    input wire mwe_wr_req_t [STACKS-1:0]      WR_REQ_I,
    input wire logic [STACKS-1:0][WORD_W-1:0] WR_WORD_O,
    input wire logic [STACKS-1:0]             WR_VLD_O,
    input wire logic [STACKS-1:0]             RD_VLD_I,
    input wire logic [STACKS-1:0][WORD_W-1:0] RD_WORD_I,
    input wire mwe_rd_rsp_t [STACKS-1:0]      RD_RSP_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    function automatic logic [CHK_W-1:0] chk(logic [DATA_W-1:0] d);
        for (int n = 0; n < CHK_W; n++) chk[n] = ~^(d & CHK_MASK[n]);
    endfunction
    mwe_wr_req_t       w;
    mwe_rd_rsp_t       r;
    logic [WORD_W-1:0] q;
    assign w = WR_REQ_I[1];
    assign r = RD_RSP_O[1];
    assign q = RD_WORD_I[1];
    a_wr_lat: assert property (w.vld |=> WR_VLD_O[1] && WR_WORD_O[1][15:0] == $past(w.data))
        else $error("write word late or wrong data");
    a_wr_chk: assert property (w.vld |=> WR_WORD_O[1][21:16] ==
        (chk($past(w.data)) ^ {6{$past(w.inv_chk)}})) else $error("check bits wrong");
    a_wr_idle: assert property (!w.vld |=> !WR_VLD_O[1] && $stable(WR_WORD_O[1]))
        else $error("write output moved without request");
    a_rd_syn: assert property (RD_VLD_I[1] |=> r.vld &&
        r.syndrome == (chk($past(q[15:0])) ^ $past(q[21:16]))) else $error("syndrome wrong");
    a_rd_idle: assert property (!RD_VLD_I[1] |=> !r.vld && $stable(r.data))
        else $error("read response moved without request");
    a_clean_pass: assert property (r.vld && r.syndrome == '0 |->
        !r.sbe && !r.mbe && r.data == $past(q[15:0])) else $error("clean word altered");
    a_flag_split: assert property (r.vld |-> !(r.sbe && r.mbe) &&
        (r.sbe || r.mbe || r.syndrome == '0)) else $error("error flags inconsistent");
    a_one_fix: assert property (r.vld && r.sbe |-> $countones(r.data ^ $past(q[15:0])) <= 1)
        else $error("correction flipped several bits");
    a_mbe_raw: assert property (r.vld && r.mbe |-> r.data == $past(q[15:0]))
        else $error("uncorrectable word was altered");
    cover property (r.vld && r.sbe);
    cover property (r.vld && r.mbe);
    cover property (w.vld && w.inv_chk);
endmodule

/* verif/mwe_stack_model.sv */
// Four storage stacks with fault injection on read
`timescale 1ns/1ps
module mwe_stack_model
    import mwe_pkg::*;
(
    // Clock and bench control
    input  wire logic                   clk_i,
    input  wire logic [3:0]             rd_req_i,
    input  wire logic [3:0]             addr_i,
    input  wire logic [WORD_W-1:0]      flip_i,
    // Block side
    input  wire logic [3:0]             wr_vld_i,
    input  wire logic [3:0][WORD_W-1:0] wr_word_i,
    output logic      [3:0]             rd_vld_o,
    output logic      [3:0][WORD_W-1:0] rd_word_o
);
    logic [WORD_W-1:0] mem [4][16];
    always @(posedge clk_i) begin
        for (int s = 0; s < 4; s++) begin
            if (wr_vld_i[s]) begin
                mem[s][addr_i] <= wr_word_i[s];
            end
            rd_vld_o[s] <= rd_req_i[s];
            rd_word_o[s] <= rd_req_i[s] ? mem[s][addr_i] ^ flip_i : ~rd_word_o[s];
        end
    end
endmodule

/* verif/mwe_top_tb.sv */
// Testbench for the memory word error-correction block
`timescale 1ns/1ps
module mwe_top_tb;
    import mwe_pkg::*;
    logic                   clk = 0;
    logic                   rst = 1;
    mwe_wr_req_t [3:0]      wr_req = '0;
    logic [3:0][WORD_W-1:0] wr_word, rd_word;
    logic [3:0]             wr_vld, rd_vld;
    logic [3:0]             rd_req = '0;
    logic [WORD_W-1:0]      flip = '0;
    mwe_rd_rsp_t [3:0]      rsp;
    int                     bad_count = 0;
    int                     num_checks = 0;
    mwe_top u_dut (.MCLK_I(clk), .SYS_RST_I(rst), .WR_REQ_I(wr_req), .WR_WORD_O(wr_word),
        .WR_VLD_O(wr_vld), .RD_VLD_I(rd_vld), .RD_WORD_I(rd_word), .RD_RSP_O(rsp));
    mwe_stack_model u_mem (.clk_i(clk), .rd_req_i(rd_req), .addr_i(4'h5), .flip_i(flip),
        .wr_vld_i(wr_vld), .wr_word_i(wr_word), .rd_vld_o(rd_vld), .rd_word_o(rd_word));
    initial forever #20 clk = ~clk;
    function automatic logic [5:0] chk(logic [15:0] d);
        for (int n = 0; n < 6; n++) chk[n] = ~^(d & CHK_MASK[n]);
    endfunction
    task cmp(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Encode d into stack s, read it back through fault mask f
    task xfer(int s, logic [15:0] d, logic inv, logic [21:0] f, logic sb, logic mb,
        logic [15:0] od);
        @(negedge clk) wr_req[s] = {1'b1, inv, d};
        @(negedge clk) wr_req[s] = '0;
        cmp({wr_vld[s], wr_word[s]}, {1'b1, chk(d) ^ {6{inv}}, d});
        @(negedge clk) rd_req[s] = 1; // Read once the write has landed
        flip = f;
        @(negedge clk) rd_req[s] = 0;
        @(negedge clk) cmp({rsp[s].vld, rsp[s].sbe, rsp[s].mbe, rsp[s].syndrome, rsp[s].data},
            {1'b1, sb, mb, chk(d ^ f[15:0]) ^ chk(d) ^ {6{inv}} ^ f[21:16], od});
    endtask
    task t_clean;
        for (int s = 0; s < 4; s++) xfer(s, 16'hA5C3 ^ (16'h3C5A * s), 0, '0, 0, 0,
            16'hA5C3 ^ (16'h3C5A * s));
        $display("clean words done");
    endtask
    task t_single;
        for (int p = 0; p < 22; p++) xfer(1, 16'hA5C3, 0, 22'h1 << p, 1, 0, 16'hA5C3);
        $display("single faults done");
    endtask
    task t_double;
        for (int p = 0; p < 21; p++) xfer(1, 16'h5A3C, 0, 22'h3 << p, 0, 1,
            16'h5A3C ^ (16'h3 << p));
        $display("double faults done");
    endtask
    task t_inv;
        xfer(1, 16'h0F0F, 1, '0, 0, 1, 16'h0F0F);
        $display("inverted checks done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        t_clean();
        t_single();
        t_double();
        t_inv();
        finish_test();
    end
endmodule
bind mwe_top mwe_checker #(.STACKS(STACKS)) u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .WR_REQ_I(WR_REQ_I), .WR_WORD_O(WR_WORD_O), .WR_VLD_O(WR_VLD_O), .RD_VLD_I(RD_VLD_I),
    .RD_WORD_I(RD_WORD_I), .RD_RSP_O(RD_RSP_O));
